/* File: rtl/irr_exec_pkg.sv */
// Constants and types shared by the increment, rotate and return executor.
package irr_exec_pkg;
  localparam int IW = 14;
  localparam int DW = 8;
  localparam int AW = 7;
  localparam int PCW = 13;
  localparam int SD = 8;
  localparam int SPW = 3;
  localparam logic [5:0] INCREMENT_FILE_OP = 6'h0a;
  localparam logic [5:0] INCREMENT_SKIP_ZERO_OP = 6'h0f;
  localparam logic [5:0] ROTATE_LEFT_CARRY_OP = 6'h0d;
  localparam logic [3:0] RETURN_WITH_LITERAL_OP = 4'hd;
  localparam logic [IW-1:0] OP_RETURN = 14'h0008;
  localparam int DBIT = 7;
  localparam logic [DW-1:0] ONE = 8'h01;
  localparam logic [DW-1:0] ZERO = 8'h00;
  localparam logic [PCW-1:0] PC_RST = 13'h0000;
  localparam logic [PCW-1:0] PC_ONE = 13'h0001;

  typedef enum logic [1:0] {
    ST_EXEC  = 2'b00,
    ST_FLUSH = 2'b01
  } exec_state_t;

  typedef struct packed {
    logic          we;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
  } file_wr_t;

  typedef struct packed {
    logic zero;
    logic carry;
  } flags_t;
endpackage : irr_exec_pkg

/* File: rtl/irr_file_ram.sv */
// Data register file with registered read data.
`timescale 1ns/1ns
module irr_file_ram
  import irr_exec_pkg::*;
(
  // Clock
  input  wire logic            sys_clk,
  // Ports
  input  wire logic [AW-1:0]   raddr,
  output logic      [DW-1:0]   rdata,
  input  wire file_wr_t        wr
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge sys_clk) begin
    if (wr.we) begin
      mem[wr.addr] <= wr.data;
    end
    rdata <= mem[raddr];
  end
endmodule : irr_file_ram

/* File: rtl/irr_exec.sv */
// Executor for increment, increment-skip, rotate-left and return words.
`timescale 1ns/1ns
module irr_exec
  import irr_exec_pkg::*;
(
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            rstn,
  // Fetched instruction
  input  wire logic [IW-1:0]   instr,
  input  wire logic            instr_valid,
  // Return address push from the call path
  input  wire logic            push,
  input  wire logic [PCW-1:0]  push_addr,
  // Core state
  output logic      [PCW-1:0]  pc_q,
  output logic      [DW-1:0]   w_q,
  output flags_t               flags_q,
  output logic                 busy_q,
  output logic                 stack_top_valid_q
);
  // The file read is registered, so each instruction other than a return is held one cycle in
  // a read phase before it executes; the fetch side must hold instr while
  // busy_q is high.
  exec_state_t              state_q, state_d;
  logic        [DW-1:0]     w_d;
  flags_t                   flags_d;
  logic        [PCW-1:0]    pc_d;
  logic        [PCW-1:0]    stack_q [SD];
  logic        [PCW-1:0]    stack_d [SD];
  logic        [SPW-1:0]    sp_q, sp_d;
  logic                     phase_q, phase_d;
  logic                     busy_d;
  logic                     stv_d;
  logic        [DW-1:0]     rdata;
  file_wr_t                 wr;
  logic        [PCW-1:0]    stack_top;

  function automatic logic [5:0] op6(input logic [IW-1:0] i);
    return i[IW-1:IW-6];
  endfunction : op6

  function automatic logic is_ret(input logic [IW-1:0] i);
    return (i == OP_RETURN) || (i[IW-1:IW-4] == RETURN_WITH_LITERAL_OP);
  endfunction : is_ret

  irr_file_ram u_ram (
    .sys_clk (sys_clk),
    .raddr   (instr[AW-1:0]),
    .rdata   (rdata),
    .wr      (wr)
  );

  assign stack_top = stack_q[SPW'(sp_q - SPW'(1))];

  always_comb begin
    logic [DW-1:0] res;
    logic          wb;
    res      = rdata + ONE;
    wb       = 1'b0;
    state_d  = state_q;
    w_d      = w_q;
    flags_d  = flags_q;
    pc_d     = pc_q;
    sp_d     = sp_q;
    stack_d  = stack_q;
    phase_d  = phase_q;
    busy_d   = busy_q;
    wr       = '{we: 1'b0, addr: instr[AW-1:0], data: ZERO};
    if (push) begin
      stack_d[sp_q] = push_addr;
      sp_d          = SPW'(sp_q + SPW'(1));
    end
    case (state_q)
      ST_EXEC: begin
        if (instr_valid && !phase_q && !is_ret(instr)) begin
          phase_d = 1'b1;
          busy_d  = 1'b1;
        end else if (instr_valid) begin
          phase_d = 1'b0;
          busy_d  = 1'b0;
          pc_d    = PCW'(pc_q + PC_ONE);
          if (op6(instr) == INCREMENT_FILE_OP) begin
            res          = rdata + ONE;
            flags_d.zero = (res == ZERO);
            wb           = 1'b1;
          end else if (op6(instr) == INCREMENT_SKIP_ZERO_OP) begin
            res = rdata + ONE;
            wb  = 1'b1;
            if (res == ZERO) begin
              state_d = ST_FLUSH;
              busy_d  = 1'b1;
            end
          end else if (op6(instr) == ROTATE_LEFT_CARRY_OP) begin
            res           = {rdata[DW-2:0], flags_q.carry};
            flags_d.carry = rdata[DW-1];
            wb            = 1'b1;
          end else if (is_ret(instr)) begin
            if (instr[IW-1:IW-4] == RETURN_WITH_LITERAL_OP) begin
              w_d = instr[DW-1:0];
            end
            pc_d    = stack_top;
            sp_d    = SPW'(sp_q - SPW'(1));
            state_d = ST_FLUSH;
            busy_d  = 1'b1;
          end
          if (wb) begin
            if (instr[DBIT]) begin
              wr.we   = 1'b1;
              wr.data = res;
            end else begin
              w_d = res;
            end
          end
        end
      end
      ST_FLUSH: begin
        // The discarded word is executed as a no-operation.
        state_d = ST_EXEC;
        busy_d  = 1'b0;
        // A skip steps past the discarded word; a return keeps its target.
        pc_d = (busy_q && !is_ret(instr)) ? PCW'(pc_q + PC_ONE) : pc_q;
      end
      default: begin
        state_d = ST_EXEC;
      end
    endcase
    stv_d = (sp_d != SPW'(0));
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q           <= ST_EXEC;
      w_q               <= ZERO;
      flags_q           <= '0;
      pc_q              <= PC_RST;
      sp_q              <= '0;
      phase_q           <= 1'b0;
      busy_q            <= 1'b0;
      stack_top_valid_q <= 1'b0;
      for (int i = 0; i < SD; i++) begin
        stack_q[i] <= PC_RST;
      end
    end else begin
      state_q           <= state_d;
      w_q               <= w_d;
      flags_q           <= flags_d;
      pc_q              <= pc_d;
      sp_q              <= sp_d;
      phase_q           <= phase_d;
      busy_q            <= busy_d;
      stack_top_valid_q <= stv_d;
      stack_q           <= stack_d;
    end
  end

  sequence s_ret_taken;
    state_q == ST_EXEC && instr_valid && is_ret(instr);
  endsequence

  a_ret_two_cycle: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_ret_taken |=> state_q == ST_FLUSH ##1 state_q == ST_EXEC)
    else $error("return did not take two cycles");
  a_return_with_literal_op_loads_w: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_ret_taken and instr[IW-1:IW-4] == RETURN_WITH_LITERAL_OP
    |=> w_q == $past(instr[DW-1:0]))
    else $error("literal not loaded");
  a_ret_pc_top: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_ret_taken and !push |=> pc_q == $past(stack_top))
    else $error("pc not loaded from stack top");
  a_ret_flags_kept: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_ret_taken |=> flags_q == $past(flags_q))
    else $error("return changed flags");
  a_increment_file_op_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_q == ST_EXEC && instr_valid && phase_q
    && op6(instr) == INCREMENT_FILE_OP
    |=> flags_q.zero == ($past(rdata) == 8'hff))
    else $error("zero flag wrong after increment");
  a_increment_file_op_carry_kept: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_q == ST_EXEC && instr_valid && phase_q
    && op6(instr) == INCREMENT_FILE_OP
    |=> flags_q.carry == $past(flags_q.carry))
    else $error("increment changed carry");
  a_skip_flush: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_q == ST_EXEC && instr_valid && phase_q
    && op6(instr) == INCREMENT_SKIP_ZERO_OP
    |=> (state_q == ST_FLUSH) == ($past(rdata) == 8'hff))
    else $error("skip decision wrong");
  a_skip_flags_kept: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_q == ST_EXEC && instr_valid && phase_q
    && op6(instr) == INCREMENT_SKIP_ZERO_OP
    |=> flags_q == $past(flags_q))
    else $error("skip increment changed flags");
  a_rlf_carry: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_q == ST_EXEC && instr_valid && phase_q
    && op6(instr) == ROTATE_LEFT_CARRY_OP
    |=> flags_q.carry == $past(rdata[DW-1]))
    else $error("rotate carry wrong");
  a_dest_w: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_q == ST_EXEC && instr_valid && phase_q
    && op6(instr) == INCREMENT_FILE_OP
    && !instr[DBIT] |=> w_q == DW'($past(rdata) + ONE))
    else $error("increment result not in working register");
endmodule : irr_exec

/* File: tb/prog_word_model.sv */
// Program memory model that presents one fetched word per request.
`timescale 1ns/1ns
module prog_word_model
  import irr_exec_pkg::*;
(
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            rstn,
  // Request from the bench
  input  wire logic            start,
  input  wire logic [IW-1:0]   word,
  // Fetched word
  output logic      [IW-1:0]   instr,
  output logic                 instr_valid
);
  logic more_q;
  logic ret_word;

  assign ret_word = (word == OP_RETURN) ||
                    (word[IW-1:IW-4] == RETURN_WITH_LITERAL_OP);

  // File words stay valid for the read and the execute cycle, returns for
  // one; the word itself is held until the next request.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      instr       <= '0;
      instr_valid <= 1'b0;
      more_q      <= 1'b0;
    end else if (start) begin
      instr       <= word;
      instr_valid <= 1'b1;
      more_q      <= !ret_word;
    end else if (instr_valid && more_q) begin
      more_q      <= 1'b0;
    end else if (instr_valid) begin
      instr_valid <= 1'b0;
    end
  end
endmodule : prog_word_model

/* File: tb/incr_rotate_return_exec_tb.sv */
// Self-checking bench for the increment, rotate and return executor.
`timescale 1ns/1ns
module incr_rotate_return_exec_tb
  import irr_exec_pkg::*;
;
  logic           sys_clk = 1'b0;
  logic           rstn = 1'b0;
  logic           start = 1'b0;
  logic [IW-1:0]  word = '0;
  logic           push = 1'b0;
  logic [PCW-1:0] push_addr = '0;
  logic [IW-1:0]  instr;
  logic           instr_valid;
  logic [PCW-1:0] pc_q;
  logic [DW-1:0]  w_q;
  flags_t         flags_q;
  logic           busy_q;
  logic           stv;
  int             errors = 0;
  int             compares = 0;

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  irr_exec DUT (.sys_clk(sys_clk), .rstn(rstn), .instr(instr),
    .instr_valid(instr_valid), .push(push), .push_addr(push_addr),
    .pc_q(pc_q), .w_q(w_q), .flags_q(flags_q), .busy_q(busy_q),
    .stack_top_valid_q(stv));

  prog_word_model mem (.sys_clk(sys_clk), .rstn(rstn), .start(start),
    .word(word), .instr(instr), .instr_valid(instr_valid));

  task automatic tally_and_finish;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic do_reset;
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
  endtask : do_reset

  // Returns the instruction's cycles: busy cycles, plus the execute cycle
  // of a return, which raises busy_q only for its flush.
  task automatic exec(input logic [IW-1:0] wd, output int n);
    logic ret;
    ret = (wd == OP_RETURN) || (wd[IW-1:IW-4] == RETURN_WITH_LITERAL_OP);
    @(posedge sys_clk);
    start <= 1'b1;
    word  <= wd;
    @(posedge sys_clk);
    start <= 1'b0;
    @(posedge sys_clk);
    n = 0;
    repeat (8) begin
      #1;
      if (busy_q !== 1'b1) break;
      n++;
      @(posedge sys_clk);
    end
    if (n == 8) begin
      errors++;
      tally_and_finish;
    end
    if (ret) n++;
  endtask : exec

  task automatic push_ret(input logic [PCW-1:0] a);
    @(posedge sys_clk);
    push      <= 1'b1;
    push_addr <= a;
    @(posedge sys_clk);
    push      <= 1'b0;
  endtask : push_ret

  task automatic t_return_with_literal_op;
    logic [7:0] k [3] = '{8'h00, 8'h5a, 8'hff};
    int n;
    do_reset;
    chk("reset", 32'({pc_q, w_q, flags_q, busy_q, stv}), 32'h0);
    for (int i = 0; i < 3; i++) begin
      push_ret(13'h0100 + 13'(i));
      exec({RETURN_WITH_LITERAL_OP, 2'(i), k[i]}, n);
      chk("w_q", 32'(w_q), 32'(k[i]));
      chk("pc_q", 32'(pc_q), 32'h0100 + 32'(i));
      chk("cycles", 32'(n), 32'h2);
      chk("flags_q", 32'(flags_q), 32'h0);
    end
    $display("test return_with_literal_op done");
  endtask : t_return_with_literal_op

  task automatic t_return;
    int n;
    do_reset;
    push_ret(13'h00a1);
    push_ret(13'h1fb2);
    exec(OP_RETURN, n);
    chk("pc_q", 32'(pc_q), 32'h1fb2);
    chk("cycles", 32'(n), 32'h2);
    chk("stack", 32'(stv), 32'h1);
    exec(OP_RETURN, n);
    chk("pc_q", 32'(pc_q), 32'h00a1);
    chk("stack", 32'(stv), 32'h0);
    chk("flags_q", 32'(flags_q), 32'h0);
    $display("test return done");
  endtask : t_return

  // File contents are not reset, so only data-independent effects are judged.
  task automatic t_file_ops;
    int n;
    do_reset;
    exec({INCREMENT_SKIP_ZERO_OP, 1'b1, 7'h10}, n);
    chk("flags_q", 32'(flags_q), 32'h0);
    do_reset;
    exec({INCREMENT_FILE_OP, 1'b1, 7'h11}, n);
    chk("pc_q", 32'(pc_q), 32'h1);
    chk("cycles", 32'(n), 32'h1);
    chk("carry", 32'(flags_q.carry), 32'h0);
    exec({ROTATE_LEFT_CARRY_OP, 1'b1, 7'h12}, n);
    chk("pc_q", 32'(pc_q), 32'h2);
    chk("cycles", 32'(n), 32'h1);
    $display("test file ops done");
  endtask : t_file_ops

  initial begin
    t_return_with_literal_op;
    t_return;
    t_file_ops;
    tally_and_finish;
  end
endmodule : incr_rotate_return_exec_tb
